// ### hw/dpar_top.sv
// dpar_top: dual path audio router, mixer and delay with apb registers.
// assumes de-embedder samples arrive with a one-cycle valid strobe and
// that embedders take aud_out whenever its valid is high.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module dpar_top #(
	parameter int DEPTH = 64,
	parameter int BASE = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// de-embedded audio and pair status
	input wire dpar_pkg::dpar_in_t aud_in,
	input wire dpar_pkg::dpar_pair_t [1:0][dpar_pkg::NPAIR-1:0] pair_st,
	// embedder audio
	output dpar_pkg::dpar_out_t aud_out
);
	import dpar_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [SMP_W-1:0] SMAX = {1'b0, {(SMP_W - 1){1'b1}}};

	// whole state of the block except the delay history mem
	typedef struct packed {
		logic [1:0][NCH-1:0][5:0] in_rt;
		logic [1:0][NCH-1:0][5:0] out_rt;
		logic [1:0][4:0][3:0] dmx_sel;
		logic [1:0][DLY_W-1:0] bulk;
		logic [1:0][NCH-1:0][DLY_W-1:0] ofs;
		logic [NCH-1:0][31:0] fin;
		logic [NCH-1:0][31:0] fout;
		logic [1:0][NHDMI-1:0][3:0] hsel;
		dpar_pair_t [1:0][NPAIR-1:0] pst;
		logic [AW-1:0] wp;
		logic [AW:0] fill;
		logic s1_v;
		logic s2_v;
		dpar_bus_t [1:0] bus;
		logic [1:0][1:0][SMP_W-1:0] dm;
		logic [1:0][1:0][SMP_W-1:0] dm_s2;
		dpar_bus_t [1:0] dly;
		dpar_out_t out;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dpar_st_t;

	// reset image: straight routing, default downmix and hdmi picks
	function automatic dpar_st_t st_rst();
		dpar_st_t s;
		s = '0;
		for (int p = 0; p < 2; p++)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				s.in_rt[p][c] = 6'(c);
				s.out_rt[p][c] = 6'(p * NCH + c);
			end
			for (int k = 0; k < NHDMI; k++)
				s.hsel[p][k] = 4'(k);
			for (int k = 0; k < 5; k++)
				s.dmx_sel[p][k] = 4'(k);
		end
		return s;
	endfunction

	localparam dpar_st_t ST_RST = st_rst();

	// sign extension and full-scale limiting
	function automatic int sx(input logic [SMP_W-1:0] v);
		return int'($signed(v));
	endfunction

	function automatic logic [SMP_W-1:0] sat(input int v);
		int lim;
		lim = 2 ** (SMP_W - 1);
		if (v >= lim)
			return SMAX;
		if (v < -lim)
			return ~SMAX;
		return SMP_W'(v);
	endfunction

	function automatic int clamp(input int v, input int lo, input int hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction

	dpar_st_t q;
	dpar_st_t n;
	logic [SMP_W-1:0] mem [2][NCH][DEPTH];
	logic [1:0][1:0][SMP_W-1:0] dm_w;
	logic [NCH-1:0][SMP_W-1:0] fin_w;
	logic [NCH-1:0][SMP_W-1:0] fout_w;
	logic [1:0][NCH-1:0][AW-1:0] eff_w;

	// next state: mixers, routers, delay taps and register access
	always_comb
	begin
		int acc;
		int e;
		logic [5:0] s;
		logic [9:0] ix;
		logic [9:0] ro;
		logic [31:0] rd;
		logic bad;
		logic wr;
		acc = 0;
		e = 0;
		s = '0;
		ro = '0;
		rd = '0;
		bad = 1'b0;
		ix = paddr[11:2];
		wr = psel && penable && q.pready && pwrite;
		n = q;

		// input nodes sum any de-embedded channel of either path
		for (int k = 0; k < NCH; k++)
		begin
			acc = 0;
			for (int j = 0; j < 2 * NCH; j++)
				if (q.fin[k][j])
					acc += sx(aud_in.smp[j / NCH][j % NCH]);
			fin_w[k] = sat(acc);
		end

		// downmix: selects are left, right, center, left and right surround
		for (int p = 0; p < 2; p++)
		begin
			acc = sx(aud_in.smp[p][q.dmx_sel[p][2]]) / 2;
			dm_w[p][0] = sat(sx(aud_in.smp[p][q.dmx_sel[p][0]]) + acc
				+ sx(aud_in.smp[p][q.dmx_sel[p][3]]) / 2);
			dm_w[p][1] = sat(sx(aud_in.smp[p][q.dmx_sel[p][1]]) + acc
				+ sx(aud_in.smp[p][q.dmx_sel[p][4]]) / 2);
		end

		// output nodes sum any delayed bus channel of either path
		for (int k = 0; k < NCH; k++)
		begin
			acc = 0;
			for (int j = 0; j < 2 * NCH; j++)
				if (q.fout[k][j])
					acc += sx(q.dly[j / NCH][j % NCH]);
			fout_w[k] = sat(acc);
		end

		// tap distance per channel; compressed pairs share the even offset
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < NCH; c++)
			begin
				e = int'($signed(q.ofs[p][c]));
				if (q.pst[p][c / 2].nonpcm)
					e = int'($signed(q.ofs[p][c - c % 2]));
				e = clamp(BASE + int'($signed(q.bulk[p])) + e, 1, DEPTH - 1);
				eff_w[p][c] = AW'(e);
			end

		// stage 1: input crosspoint onto the internal buses
		n.s1_v = aud_in.valid;
		n.pst = pair_st;
		if (aud_in.valid)
		begin
			n.dm = dm_w;
			for (int p = 0; p < 2; p++)
				for (int c = 0; c < NCH; c++)
				begin
					s = q.in_rt[p][c];
					if (s < SRC_DMX)
						n.bus[p][c] = aud_in.smp[p][s[3:0]];
					else if (s < SRC_FLEX)
						n.bus[p][c] = dm_w[p][s[0]];
					else if (s < SRC_NONE)
						n.bus[p][c] = fin_w[4'(s - SRC_FLEX)];
					else
						n.bus[p][c] = '0;
				end
		end

		// stage 2: delay taps; unfilled history reads as silence
		n.s2_v = q.s1_v;
		if (q.s1_v)
		begin
			// carry the downmix along so stage 3 shows the same sample's mix
			n.dm_s2 = q.dm;
			n.wp = q.wp + 1'b1;
			if (q.fill < (AW + 1)'(DEPTH))
				n.fill = q.fill + 1'b1;
			for (int p = 0; p < 2; p++)
				for (int c = 0; c < NCH; c++)
					if ({1'b0, eff_w[p][c]} <= q.fill)
						n.dly[p][c] = mem[p][c][q.wp - eff_w[p][c]];
					else
						n.dly[p][c] = '0;
		end

		// stage 3: output crosspoint and hdmi channel picks
		n.out.valid = q.s2_v;
		if (q.s2_v)
			for (int p = 0; p < 2; p++)
			begin
				for (int c = 0; c < NCH; c++)
				begin
					s = q.out_rt[p][c];
					if (s < OSRC_DMX)
						n.out.sdi[p][c] = q.dly[s[4]][s[3:0]];
					else if (s < OSRC_FLEX)
						n.out.sdi[p][c] = q.dm_s2[p][s[0]];
					else if (s < OSRC_NONE)
						n.out.sdi[p][c] = fout_w[4'(s - OSRC_FLEX)];
					else
						n.out.sdi[p][c] = '0;
				end
				for (int k = 0; k < NHDMI; k++)
					n.out.hdmi[p][k] = q.dly[p][q.hsel[p][k]];
			end

		// register decode; writes land on the edge that completes the transfer
		if (ix < IX_OUT_RT)
		begin
			rd = 32'(q.in_rt[ix[4]][ix[3:0]]);
			if (wr)
				n.in_rt[ix[4]][ix[3:0]] = pwdata[5:0];
		end
		else if (ix < IX_DMX)
		begin
			ro = ix - IX_OUT_RT;
			rd = 32'(q.out_rt[ro[4]][ro[3:0]]);
			if (wr)
				n.out_rt[ro[4]][ro[3:0]] = pwdata[5:0];
		end
		else if (ix < IX_BULK)
		begin
			rd = 32'(q.dmx_sel[ix[0]]);
			if (wr)
				n.dmx_sel[ix[0]] = pwdata[19:0];
		end
		else if (ix < IX_OFS)
		begin
			rd = 32'($signed(q.bulk[ix[0]]));
			if (wr)
				n.bulk[ix[0]] = DLY_W'(clamp(int'(pwdata), BULK_MIN_S, BULK_MAX_S));
		end
		else if (ix < IX_FIN)
		begin
			ro = ix - IX_OFS;
			rd = 32'($signed(q.ofs[ro[4]][ro[3:0]]));
			if (wr)
				n.ofs[ro[4]][ro[3:0]] = DLY_W'(clamp(int'(pwdata), -OFS_MAX_S, OFS_MAX_S));
		end
		else if (ix < IX_FOUT)
		begin
			ro = ix - IX_FIN;
			rd = q.fin[ro[3:0]];
			if (wr)
				n.fin[ro[3:0]] = pwdata;
		end
		else if (ix < IX_HDMI)
		begin
			ro = ix - IX_FOUT;
			rd = q.fout[ro[3:0]];
			if (wr)
				n.fout[ro[3:0]] = pwdata;
		end
		else if (ix < IX_PST)
		begin
			rd = q.hsel[ix[0]];
			if (wr)
				n.hsel[ix[0]] = pwdata;
		end
		else if (ix < IX_END)
			rd = 32'(q.pst[ix[0]]);
		else
			bad = 1'b1;

		// one wait state, then a registered answer
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !q.pready)
		begin
			n.pready = 1'b1;
			n.prdata = rd;
			n.pslverr = bad;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= ST_RST;
		else
			q <= n;
	end

	// delay history, one entry per channel per sample
	always_ff @(posedge pclk)
	begin
		if (q.s1_v)
			for (int p = 0; p < 2; p++)
				for (int c = 0; c < NCH; c++)
					mem[p][c][q.wp] <= q.bus[p][c];
	end

	// outputs come straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign aud_out = q.out;

	// assertions and cover points
	default clocking dpar_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_path_indep;
		psel && penable && pready && pwrite && paddr[11:2] < 10'h010 |=> $stable(q.in_rt[1]);
	endproperty
	a_path_indep: assert property (p_path_indep)
		else $error("path 0 route write changed path 1");

	property p_in_route;
		aud_in.valid && q.in_rt[1][0] == 6'h03 |=> q.bus[1][0] == $past(aud_in.smp[1][3]);
	endproperty
	a_in_route: assert property (p_in_route)
		else $error("bus channel not taken from its source");

	property p_flex_sat;
		aud_in.valid && q.fin[0] == 32'h0000_0003 && q.in_rt[0][4] == SRC_FLEX
			&& !aud_in.smp[0][0][SMP_W-1] && !aud_in.smp[0][1][SMP_W-1]
			|=> !q.bus[0][4][SMP_W-1];
	endproperty
	a_flex_sat: assert property (p_flex_sat)
		else $error("summing node wrapped instead of limiting");

	property p_bulk_rng;
		$signed(q.bulk[1]) >= BULK_MIN_S && $signed(q.bulk[1]) <= BULK_MAX_S;
	endproperty
	a_bulk_rng: assert property (p_bulk_rng)
		else $error("bulk delay outside its range");

	property p_pair_ofs;
		q.pst[0][3].nonpcm |-> eff_w[0][6] == eff_w[0][7];
	endproperty
	a_pair_ofs: assert property (p_pair_ofs)
		else $error("compressed pair channels delayed apart");

	property p_out_route;
		q.s2_v && q.out_rt[1][0] == 6'h03 |=> aud_out.sdi[1][0] == $past(q.dly[0][3]);
	endproperty
	a_out_route: assert property (p_out_route)
		else $error("output not cross-sourced from path 0 bus");

	property p_pair_stat;
		psel && penable && !pready && !pwrite && paddr[11:2] == IX_PST
			|=> prdata[23:0] == $past(pair_st[0], 2);
	endproperty
	a_pair_stat: assert property (p_pair_stat)
		else $error("pair status read does not match inputs");

	property p_hdmi_pick;
		q.s2_v && q.hsel[0][2] == 4'h9 |=> aud_out.hdmi[0][2] == $past(q.dly[0][9]);
	endproperty
	a_hdmi_pick: assert property (p_hdmi_pick)
		else $error("hdmi channel not taken from chosen bus channel");

	c_out_valid: cover property (aud_out.valid);
	c_nonpcm: cover property (q.s1_v && q.pst[0][0].nonpcm);
	c_slverr: cover property (pready && pslverr);
endmodule

// ### include/dpar_pkg.sv
// dpar_pkg: constants, register indices and carrier types of the dual path
// audio router and mixer.
// assumes a 32-bit apb master and sample strobes from the de-embedders.
package dpar_pkg;
	// stream geometry
	localparam int SMP_W = 24;
	localparam int NCH = 16;
	localparam int NPAIR = 8;
	localparam int NHDMI = 8;
	localparam int FS_HZ = 48000;
	// delay limits in ms, then in samples
	localparam int BULK_MIN_MS = -33;
	localparam int BULK_MAX_MS = 3000;
	localparam int OFS_MAX_MS = 800;
	localparam int BULK_MIN_S = BULK_MIN_MS * FS_HZ / 1000;
	localparam int BULK_MAX_S = BULK_MAX_MS * FS_HZ / 1000;
	localparam int OFS_MAX_S = OFS_MAX_MS * FS_HZ / 1000;
	localparam int DLY_W = 20;
	// word indices; byte address is four times the index
	localparam logic [9:0] IX_IN_RT = 10'h000;
	localparam logic [9:0] IX_OUT_RT = 10'h020;
	localparam logic [9:0] IX_DMX = 10'h040;
	localparam logic [9:0] IX_BULK = 10'h042;
	localparam logic [9:0] IX_OFS = 10'h044;
	localparam logic [9:0] IX_FIN = 10'h064;
	localparam logic [9:0] IX_FOUT = 10'h074;
	localparam logic [9:0] IX_HDMI = 10'h084;
	localparam logic [9:0] IX_PST = 10'h086;
	localparam logic [9:0] IX_END = 10'h088;
	// input router source codes
	localparam logic [5:0] SRC_DMX = 6'h10;
	localparam logic [5:0] SRC_FLEX = 6'h12;
	localparam logic [5:0] SRC_NONE = 6'h22;
	// output router source codes
	localparam logic [5:0] OSRC_DMX = 6'h20;
	localparam logic [5:0] OSRC_FLEX = 6'h22;
	localparam logic [5:0] OSRC_NONE = 6'h32;
	// carriers
	typedef logic [NCH-1:0][SMP_W-1:0] dpar_bus_t;
	typedef struct packed {
		logic valid;
		dpar_bus_t [1:0] smp;
	} dpar_in_t;
	typedef struct packed {
		logic present;
		logic locked;
		logic nonpcm;
	} dpar_pair_t;
	typedef struct packed {
		logic valid;
		dpar_bus_t [1:0] sdi;
		logic [1:0][NHDMI-1:0][SMP_W-1:0] hdmi;
	} dpar_out_t;
endpackage

// ### bench/dpar_src.sv
// dpar_src: de-embedder stand-in that feeds samples and pair status.
// assumes the router takes aud_in on any edge where valid is high.
`timescale 1ns/1ps
module dpar_src (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pacing: run enables strobes, fast makes them back to back
	input wire logic run,
	input wire logic fast,
	// audio and status towards the router
	output dpar_pkg::dpar_in_t aud_in,
	output dpar_pkg::dpar_pair_t [1:0][dpar_pkg::NPAIR-1:0] pair_st
);
	import dpar_pkg::*;
	int seed = 32'h2187;
	logic v;
	// strobe with random gaps when slow; idle sample lines toggle every cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			aud_in <= '0;
			pair_st <= '0;
		end
		else
		begin
			v = run && (fast || $random(seed) % 2 == 0);
			aud_in.valid <= v;
			for (int p = 0; p < 2; p++)
			begin
				for (int c = 0; c < NCH; c++)
				begin
					aud_in.smp[p][c] <= v ? 24'($random(seed)) & 24'h7FFFFF : ~aud_in.smp[p][c];
				end
			end
			if (v)
				pair_st <= 48'({$random(seed), $random(seed)});
		end
	end
endmodule

// ### bench/dpar_top_bench.sv
// dpar_top_bench: drives apb and audio, compares with a queue model.
// assumes the source stand-in dpar_src and a short delay history.
`timescale 1ns/1ps
module dpar_top_bench;
	import dpar_pkg::*;
	typedef int dpar_hist_t [2][16];
	typedef int dpar_dm_t [2][2];
	localparam int DEPTH = 8;
	localparam int BASE = 2;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, fast = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er;
	dpar_in_t aud_in;
	dpar_pair_t [1:0][NPAIR-1:0] pair_st;
	dpar_out_t aud_out;
	int n_fail = 0, checked = 0, cyc = 0, in_n = 0, out_n = 0;
	int in_rt[32], out_rt[32], bulk[2];
	int ofs[32];
	logic [31:0] fin[16], hsel[2];
	dpar_hist_t busq[$];
	dpar_dm_t dmq[$];
	dpar_pair_t [1:0][NPAIR-1:0] pstq[$];
	dpar_top #(.DEPTH(DEPTH), .BASE(BASE)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .aud_in(aud_in),
		.pair_st(pair_st), .aud_out(aud_out));
	dpar_src src_u (.pclk(pclk), .presetn(presetn), .run(run), .fast(fast),
		.aud_in(aud_in), .pair_st(pair_st));
	// clock and hang guard
	always #2.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			final_report();
		end
	end
	// model helpers
	function automatic int sat(input int x);
		return x > 8388607 ? 8388607 : (x < -8388608 ? -8388608 : x);
	endfunction
	function automatic int sv(input int p, input int c);
		return $signed(aud_in.smp[p][c]);
	endfunction
	function automatic int fx(input int k);
		int a;
		a = 0;
		for (int j = 0; j < 32; j++)
			if (fin[k][j])
				a += sv(j / 16, j % 16);
		return sat(a);
	endfunction
	// compressed pairs take the even channel's offset
	function automatic int dly(input int p, input int c, input int j);
		int e;
		int cc;
		cc = pstq[j][p][c / 2].nonpcm ? c - c % 2 : c;
		e = BASE + bulk[p] + ofs[p * 16 + cc];
		e = e < 1 ? 1 : (e > DEPTH - 1 ? DEPTH - 1 : e);
		return j - e < 0 ? 0 : busq[j - e][p][c];
	endfunction
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_smp(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t smp got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; writes also update the model
	task automatic apb(input logic w, input int ix, input logic [31:0] d);
		int b;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= 12'(ix * 4);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		b = $signed(d);
		if (w && ix < 32) in_rt[ix] = int'(d[5:0]);
		if (w && ix >= 32 && ix < 64) out_rt[ix - 32] = int'(d[5:0]);
		if (w && (ix == IX_BULK || ix == IX_BULK + 1))
			bulk[ix - IX_BULK] = b < -1584 ? -1584 : (b > 144000 ? 144000 : b);
		if (w && ix >= IX_OFS && ix < IX_FIN)
			ofs[ix - IX_OFS] = b < -OFS_MAX_S ? -OFS_MAX_S : (b > OFS_MAX_S ? OFS_MAX_S : b);
		if (w && ix >= IX_FIN && ix < IX_FOUT)
			fin[ix - IX_FIN] = d;
		if (w && (ix == IX_HDMI || ix == IX_HDMI + 1))
			hsel[ix - IX_HDMI] = d;
	endtask
	// input side of the model: build the bus at each strobe
	always @(posedge pclk)
	begin
		dpar_hist_t b;
		dpar_dm_t m;
		int r;
		if (aud_in.valid === 1'b1)
		begin
			for (int p = 0; p < 2; p++)
			begin
				m[p][0] = sat(sv(p, 0) + sv(p, 2) / 2 + sv(p, 3) / 2);
				m[p][1] = sat(sv(p, 1) + sv(p, 2) / 2 + sv(p, 4) / 2);
				for (int c = 0; c < 16; c++)
				begin
					r = in_rt[p * 16 + c];
					b[p][c] = r < 16 ? sv(p, r) : (r < 18 ? m[p][r - 16] : (r < 34 ? fx(r - 18) : 0));
				end
			end
			busq.push_back(b);
			dmq.push_back(m);
			pstq.push_back(pair_st);
			in_n++;
		end
	end
	// output side: compare every embedder sample
	always @(posedge pclk)
	begin
		int o;
		int s;
		if (aud_out.valid === 1'b1)
		begin
			for (int p = 0; p < 2; p++)
			begin
				for (int c = 0; c < 16; c++)
				begin
					o = out_rt[p * 16 + c];
					s = o < 32 ? dly(o / 16, o % 16, out_n) : (o < 34 ? dmq[out_n][p][o - 32] : 0);
					cmp_smp(aud_out.sdi[p][c], 24'(s));
					if (c < NHDMI)
						cmp_smp(aud_out.hdmi[p][c], 24'(dly(p, int'(hsel[p][4 * c +: 4]), out_n)));
				end
			end
			out_n++;
		end
	end
	// run n strobes, then let the tail drain
	task automatic stream(input int n, input logic f);
		int t;
		t = in_n + n;
		fast <= f;
		run <= 1'b1;
		while (in_n < t) @(posedge pclk);
		run <= 1'b0;
		repeat (8) @(posedge pclk);
		cmp_reg(out_n, in_n);
	endtask
	task automatic final_report;
		$display("counts: checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial
	begin
		for (int i = 0; i < 32; i++)
		begin
			in_rt[i] = i % 16;
			out_rt[i] = i;
			ofs[i] = 0;
			fin[i % 16] = '0;
		end
		bulk = '{0, 0};
		hsel = '{32'h76543210, 32'h76543210};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			apb(0, i, 0);
			cmp_reg(rd, i < 32 ? i % 16 : i - 32);
		end
		apb(0, IX_DMX, 0);
		cmp_reg(rd, 32'h00043210);
		apb(0, IX_END, 0);
		cmp_reg({rd[30:0], er}, 32'h1);
		$display("test reset registers done");
		stream(30, 1);
		stream(30, 0);
		apb(1, IX_PST, 32'hFFFFFF);
		for (int p = 0; p < 2; p++)
		begin
			apb(0, IX_PST + p, 0);
			cmp_reg(rd, {8'h00, pair_st[p]});
		end
		$display("test identity stream and status done");
		apb(1, 5, SRC_DMX);
		apb(1, 6, SRC_DMX + 1);
		apb(1, 16, 3);
		apb(1, 33, 17);
		apb(1, 48, 3);
		apb(1, 34, 32);
		apb(1, 4, SRC_FLEX);
		apb(1, IX_FIN, 3);
		apb(1, IX_OFS + 6, 50000);
		apb(0, IX_OFS + 6, 0);
		cmp_reg(rd, OFS_MAX_S);
		apb(1, IX_OFS + 6, 6);
		apb(1, IX_OFS + 7, 4);
		apb(1, IX_HDMI, 32'h76543910);
		apb(0, 5, 0);
		cmp_reg(rd, SRC_DMX);
		apb(1, IX_BULK + 1, 200000);
		apb(0, IX_BULK + 1, 0);
		cmp_reg(rd, 144000);
		apb(1, IX_BULK + 1, 3);
		apb(1, IX_BULK, 32'hFFFFFFFB);
		stream(30, 1);
		stream(20, 0);
		$display("test routing, downmix and delay done");
		final_report();
	end
endmodule
